// [src/cctmr_pkg.sv]
// constants for the completion cache discard timer
// Summary of operation
// RL1: a miss-limit discard fires only once the idle count reaches the floor.
// RL2: cached data is discarded once the idle count reaches the ceiling.
// RL3: reads of either limit register return zero in bits 15 to 12.
// RL4: link, global pin or power-on reset returns both limits to defaults.
// RL5: cycle starts with no read hit or cache fill are counted against the miss limit.
// RL6: a read hit or new data entering the cache restarts the idle count.
package cctmr_pkg;
  localparam logic [7:0] CCTMR_OFS_MISS = 8'h52;
  localparam logic [7:0] CCTMR_OFS_FLOOR = 8'h54;
  localparam logic [7:0] CCTMR_OFS_CEIL = 8'h56;
  localparam logic [7:0] CCTMR_MISS_RST = 8'h08;
  localparam logic [11:0] CCTMR_FLOOR_RST = 12'h07F;
  localparam logic [11:0] CCTMR_CEIL_RST = 12'h1C0;
  localparam int CCTMR_LIM_W = 12;
  localparam int CCTMR_MISS_W = 8;
  localparam logic [11:0] CCTMR_IDLE_MAX = 12'hFFF;
  localparam logic [7:0] CCTMR_MISS_MAX = 8'hFF;
endpackage : cctmr_pkg

// [src/cctmr_top.sv]
// completion cache idle discard timer with its limit registers
`timescale 1ns/1ps
module cctmr_top (
  // clock and resets
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic LINK_RST_N,
  input wire logic GLOBAL_RESET_PIN_N,
  input wire logic POR_N,
  // register port
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  // cache events
  input wire logic READ_HIT,
  input wire logic CACHE_FILL,
  input wire logic CYCLE_START,
  // discard request
  output logic DISCARD
);
  logic rst_n;
  logic [11:0] floor_reg, floor_next;
  logic [11:0] ceil_reg, ceil_next;
  logic [7:0] miss_reg, miss_next;
  logic [11:0] idle_reg, idle_next;
  logic [7:0] starts_reg, starts_next;
  logic [15:0] rdata_reg, rdata_next;
  logic discard_reg, discard_next;
  logic restart;
  logic floor_ok, ceil_hit, miss_hit;
  logic [11:0] wr_lim;
  logic [7:0] wr_miss;

  // both limit registers read back with their reserved top bits as zero
  function automatic logic [15:0] lim_word(input logic [11:0] v);
    return {4'h0, v}; // RL3
  endfunction : lim_word

  // counters saturate so a long idle spell never wraps back to fresh
  function automatic logic [11:0] idle_step(input logic [11:0] v);
    if (v == cctmr_pkg::CCTMR_IDLE_MAX) begin
      return v;
    end
    return v + 12'h001;
  endfunction : idle_step

  function automatic logic [7:0] starts_step(input logic [7:0] v);
    if (v == cctmr_pkg::CCTMR_MISS_MAX) begin
      return v;
    end
    return v + 8'h01;
  endfunction : starts_step

  // any of the reset sources brings the limits back
  assign rst_n = NRST & LINK_RST_N & GLOBAL_RESET_PIN_N & POR_N; // RL4
  // a fill restarts the count too, so fresh data is never dropped at once
  assign restart = READ_HIT | CACHE_FILL; // RL6
  assign wr_lim = REG_WDATA[cctmr_pkg::CCTMR_LIM_W-1:0];
  assign wr_miss = REG_WDATA[cctmr_pkg::CCTMR_MISS_W-1:0];
  assign floor_ok = idle_reg >= floor_reg; // RL1
  assign ceil_hit = idle_reg >= ceil_reg; // RL2
  assign miss_hit = starts_reg >= miss_reg; // RL5
  assign DISCARD = discard_reg;
  assign REG_RDATA = rdata_reg;

  always_comb begin
    floor_next = floor_reg;
    ceil_next = ceil_reg;
    miss_next = miss_reg;
    rdata_next = rdata_reg;
    if (REG_WR) begin
      case (REG_ADDR)
        cctmr_pkg::CCTMR_OFS_FLOOR: begin
          floor_next = wr_lim;
        end
        cctmr_pkg::CCTMR_OFS_CEIL: begin
          ceil_next = wr_lim;
        end
        cctmr_pkg::CCTMR_OFS_MISS: begin
          miss_next = wr_miss;
        end
        default: begin
        end
      endcase
    end
    if (REG_RD) begin
      case (REG_ADDR)
        cctmr_pkg::CCTMR_OFS_FLOOR: rdata_next = lim_word(floor_reg); // RL3
        cctmr_pkg::CCTMR_OFS_CEIL: rdata_next = lim_word(ceil_reg); // RL3
        cctmr_pkg::CCTMR_OFS_MISS: rdata_next = {8'h00, miss_reg};
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_comb begin
    idle_next = idle_reg;
    starts_next = starts_reg;
    discard_next = 1'b0;
    if (restart) begin
      idle_next = 12'h000; // RL6
      starts_next = 8'h00;
    end else begin
      idle_next = idle_step(idle_reg); // RL2
      if (CYCLE_START) begin
        starts_next = starts_step(starts_reg); // RL5
      end
      discard_next = ceil_hit | (floor_ok & miss_hit); // RL1 RL2
    end
  end

  always_ff @(posedge MCLK) begin
    if (!rst_n) begin
      floor_reg <= cctmr_pkg::CCTMR_FLOOR_RST; // RL4
      ceil_reg <= cctmr_pkg::CCTMR_CEIL_RST; // RL4
      miss_reg <= cctmr_pkg::CCTMR_MISS_RST;
      idle_reg <= 12'h000;
      starts_reg <= 8'h00;
      rdata_reg <= 16'h0000;
      discard_reg <= 1'b0;
    end else begin
      floor_reg <= floor_next;
      ceil_reg <= ceil_next;
      miss_reg <= miss_next;
      idle_reg <= idle_next;
      starts_reg <= starts_next;
      rdata_reg <= rdata_next;
      discard_reg <= discard_next;
    end
  end

  sequence s_restart;
    READ_HIT || CACHE_FILL;
  endsequence

  // sampled reset here, since the flops see the reset level of the edge
  sequence s_idle_cycle;
    rst_n && !READ_HIT && !CACHE_FILL;
  endsequence

  sequence s_floor_write;
    rst_n && REG_WR && REG_ADDR == cctmr_pkg::CCTMR_OFS_FLOOR;
  endsequence

  sequence s_ceil_write;
    rst_n && REG_WR && REG_ADDR == cctmr_pkg::CCTMR_OFS_CEIL;
  endsequence

  sequence s_miss_write;
    rst_n && REG_WR && REG_ADDR == cctmr_pkg::CCTMR_OFS_MISS;
  endsequence

  sequence s_limit_read;
    REG_RD && (REG_ADDR == cctmr_pkg::CCTMR_OFS_FLOOR ||
    REG_ADDR == cctmr_pkg::CCTMR_OFS_CEIL);
  endsequence

  AST_READ_RSVD: assert property (@(posedge MCLK) disable iff (!rst_n) // RL3
    s_limit_read |=> (REG_RDATA >> cctmr_pkg::CCTMR_LIM_W) == 16'h0000)
    else $error("reserved limit bits not zero");

  AST_RESTART: assert property (@(posedge MCLK) disable iff (!rst_n) // RL6
    s_restart |=> idle_reg == 12'h000 && !DISCARD)
    else $error("idle counter did not restart");

  AST_START_CLR: assert property (@(posedge MCLK) disable iff (!rst_n) // RL5
    s_restart |=> starts_reg == 8'h00)
    else $error("cycle start count did not restart");

  AST_CEIL: assert property (@(posedge MCLK) disable iff (!rst_n) // RL2
    s_idle_cycle ##0 (idle_reg >= ceil_reg) |=> DISCARD)
    else $error("no discard at ceiling");

  AST_FLOOR: assert property (@(posedge MCLK) disable iff (!rst_n) // RL1
    DISCARD && $past(idle_reg) < $past(ceil_reg) |->
    $past(idle_reg) >= $past(floor_reg))
    else $error("miss discard before floor");

  AST_EARLY: assert property (@(posedge MCLK) disable iff (!rst_n) // RL1
    s_idle_cycle ##0 (idle_reg < floor_reg && idle_reg < ceil_reg) |=>
    !DISCARD)
    else $error("discard before floor");

  AST_MISS: assert property (@(posedge MCLK) disable iff (!rst_n) // RL5
    s_idle_cycle ##0 (idle_reg >= floor_reg && starts_reg >= miss_reg) |=>
    DISCARD)
    else $error("no discard at miss limit");

  AST_QUIET: assert property (@(posedge MCLK) disable iff (!rst_n) // RL5
    s_idle_cycle ##0 (idle_reg < ceil_reg && starts_reg < miss_reg) |=>
    !DISCARD)
    else $error("discard below miss limit");

  AST_IDLE_STEP: assert property (@(posedge MCLK) disable iff (!rst_n) // RL2
    s_idle_cycle ##0 (idle_reg != cctmr_pkg::CCTMR_IDLE_MAX) |=>
    idle_reg == $past(idle_reg) + 12'h001)
    else $error("idle counter did not advance");

  AST_IDLE_SAT: assert property (@(posedge MCLK) disable iff (!rst_n) // RL2
    s_idle_cycle ##0 (idle_reg == cctmr_pkg::CCTMR_IDLE_MAX) |=>
    idle_reg == cctmr_pkg::CCTMR_IDLE_MAX)
    else $error("idle counter wrapped");

  AST_START_STEP: assert property (@(posedge MCLK) disable iff (!rst_n) // RL5
    s_idle_cycle ##0 (CYCLE_START &&
    starts_reg != cctmr_pkg::CCTMR_MISS_MAX) |=>
    starts_reg == $past(starts_reg) + 8'h01)
    else $error("cycle start count did not advance");

  AST_START_HOLD: assert property (@(posedge MCLK) disable iff (!rst_n) // RL5
    s_idle_cycle ##0 (!CYCLE_START) |=> $stable(starts_reg))
    else $error("cycle start count moved without a start");

  AST_WR_FLOOR: assert property (@(posedge MCLK) disable iff (!rst_n) // RL1
    s_floor_write |=> floor_reg == $past(wr_lim))
    else $error("floor write lost");

  AST_WR_CEIL: assert property (@(posedge MCLK) disable iff (!rst_n) // RL2
    s_ceil_write |=> ceil_reg == $past(wr_lim))
    else $error("ceiling write lost");

  AST_WR_MISS: assert property (@(posedge MCLK) disable iff (!rst_n) // RL5
    s_miss_write |=> miss_reg == $past(wr_miss))
    else $error("miss limit write lost");

  AST_RESET: assert property (@(posedge MCLK) // RL4
    !rst_n |=> floor_reg == cctmr_pkg::CCTMR_FLOOR_RST &&
    ceil_reg == cctmr_pkg::CCTMR_CEIL_RST &&
    miss_reg == cctmr_pkg::CCTMR_MISS_RST)
    else $error("limits not at defaults after reset");
endmodule : cctmr_top

// [bench/cctmr_top_tb.sv]
// self-checking bench for the cache discard timer
`timescale 1ns/1ps
module cctmr_top_tb;
  logic MCLK = 0, NRST = 0, LINK_RST_N = 1, REG_WR = 0, REG_RD = 0;
  logic GLOBAL_RESET_PIN_N = 1, POR_N = 1;
  logic READ_HIT = 0, CACHE_FILL = 0, CYCLE_START = 0, DISCARD;
  logic [7:0] REG_ADDR = 8'h00;
  logic [15:0] REG_WDATA = 16'h0000, REG_RDATA;
  int mismatches = 0, checked = 0, cycles = 0;
  cctmr_top dut (.MCLK(MCLK), .NRST(NRST), .LINK_RST_N(LINK_RST_N),
    .GLOBAL_RESET_PIN_N(GLOBAL_RESET_PIN_N), .POR_N(POR_N),
    .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .READ_HIT(READ_HIT), .CACHE_FILL(CACHE_FILL),
    .CYCLE_START(CYCLE_START), .DISCARD(DISCARD));
  always #5 MCLK = ~MCLK;
  // whole run needs about 110 cycles
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge MCLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge MCLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    #1 chk("rdata", e, REG_RDATA);
  endtask : rd
  // one-cycle event: 0 hit, 1 fill, 2 start, 3 link, 4 pin, 5 power-on reset
  task automatic ev(input int k);
    @(posedge MCLK);
    {POR_N, GLOBAL_RESET_PIN_N, LINK_RST_N, CYCLE_START, CACHE_FILL,
      READ_HIT} <= 6'h38 ^ (6'h01 << k);
    @(posedge MCLK);
    {POR_N, GLOBAL_RESET_PIN_N, LINK_RST_N, CYCLE_START, CACHE_FILL,
      READ_HIT} <= 6'h38;
  endtask : ev
  task automatic chk_dis(input int n, input logic e);
    repeat (n) @(posedge MCLK);
    #1 chk("discard", {15'h0000, e}, {15'h0000, DISCARD});
  endtask : chk_dis
  task automatic s_ceiling();
    wr(8'h56, 16'hF004);
    rd(8'h56, 16'h0004);
    for (int k = 0; k < 2; k++) begin
      ev(k);
      chk_dis(4, 1'b0);
      chk_dis(1, 1'b1);
    end
  endtask : s_ceiling
  task automatic s_floor();
    wr(8'h56, 16'h0FFF);
    wr(8'h54, 16'hF003);
    wr(8'h52, 16'h0001);
    ev(0);
    chk_dis(6, 1'b0);
    ev(0);
    ev(2);
    chk_dis(1, 1'b0);
    chk_dis(1, 1'b1);
  endtask : s_floor
  task automatic s_regs();
    rd(8'h54, 16'h007F);
    rd(8'h56, 16'h01C0);
    rd(8'h52, 16'h0008);
    wr(8'h54, 16'hFABC);
    rd(8'h54, 16'h0ABC);
    wr(8'h58, 16'hFFFF);
    rd(8'h58, 16'h0000);
    rd(8'h54, 16'h0ABC);
  endtask : s_regs
  // link, pin and power-on reset in turn must bring both limits back
  task automatic s_reset();
    for (int k = 3; k < 6; k++) begin
      wr(8'h54, 16'h0123);
      wr(8'h56, 16'h0456);
      rd(8'h56, 16'h0456);
      ev(k);
      rd(8'h54, 16'h007F);
      rd(8'h56, 16'h01C0);
    end
  endtask : s_reset
  initial begin
    repeat (20) @(posedge MCLK);
    NRST <= 1'b1;
    s_regs();
    s_ceiling();
    s_floor();
    s_reset();
    report_and_stop();
  end
endmodule : cctmr_top_tb
